// >>> rtl/pmta_irq_clear.sv
// Interrupt flag clear and peripheral acknowledge in the cycle after an external table write
`timescale 1ns/1ps
module pmta_irq_clear
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic write_done,
  input wire logic [2:0] core_flag_pending,
  input wire logic peripheral_pending,
  output logic [2:0] core_flag_clear,
  output logic peripheral_ack
);
  logic seen_q;
  logic seen_d;
  logic [2:0] clear_d;
  logic [2:0] clear_q;
  logic ack_q;
  logic ack_d;
  wire logic any_pending;

  assign any_pending = (|core_flag_pending) | peripheral_pending;
  // Remember any interrupt pending before or during the write
  assign seen_d = write_done ? 1'b0 : (seen_q | any_pending);

  // RL4 priority flag clear
  assign clear_d = !(write_done && (seen_q || any_pending)) ? 3'h0 :
    core_flag_pending[pmta_pkg::src_ext_pin] ? 3'h1 :
    core_flag_pending[pmta_pkg::src_timer_zero] ? 3'h2 :
    core_flag_pending[pmta_pkg::src_timer_clock] ? 3'h4 : 3'h0;
  // RL4 else peripheral acknowledge
  assign ack_d = write_done && (seen_q || any_pending) && (clear_d == 3'h0)
    && peripheral_pending;

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      seen_q <= 1'b0;
      clear_q <= 3'h0;
      ack_q <= 1'b0;
    end
    else
    begin
      seen_q <= seen_d;
      clear_q <= clear_d;
      ack_q <= ack_d;
    end
  end

  assign core_flag_clear = clear_q;
  assign peripheral_ack = ack_q;
endmodule // pmta_irq_clear

// >>> rtl/pmta_pkg.sv
// Package for the program memory table access block
package pmta_pkg;
  localparam int unsigned ptr_width = 16;
  localparam int unsigned word_width = 16;
  localparam int unsigned byte_width = 8;
  localparam logic [15:0] ptr_reset = 16'h0000;
  localparam logic [15:0] latch_reset = 16'h0000;
  localparam logic [15:0] ptr_step = 16'h0001;
  // Bus phase counts inside one instruction cycle pair
  localparam logic [1:0] write_cycles = 2'h2;
  // Interrupt source indexes, highest priority first
  localparam int unsigned src_ext_pin = 0;
  localparam int unsigned src_timer_zero = 1;
  localparam int unsigned src_timer_clock = 2;
  localparam int unsigned src_count = 3;

  // Operation codes from the core
  typedef enum logic [2:0]
  {
    pmta_op_latch_load = 3'h0,
    pmta_op_latch_read = 3'h1,
    pmta_op_table_write = 3'h2,
    pmta_op_table_read = 3'h3,
    pmta_op_ptr_load = 3'h4
  } pmta_op_type;

  typedef enum logic [4:0]
  {
    pmta_st_idle = 5'h01,
    pmta_st_wr_first = 5'h02,
    pmta_st_wr_second = 5'h04,
    pmta_st_rd_first = 5'h08,
    pmta_st_rd_second = 5'h10
  } pmta_state_type;
endpackage

// >>> rtl/pmta_table_access.sv
// Table pointer, table latch and program memory access sequencer
// Summary of operation
// RL1 - External table write always takes exactly two instruction cycles.
// RL2 - Second cycle of external table write drives the latched word out.
// RL3 - Pending or arriving interrupt never aborts an external table write.
// RL4 - Write with interrupt clears highest external flag or acknowledges peripheral.
// RL5 - Increment operand set bumps pointer after access; clear leaves it.
// RL6 - Table read fetches word at pointer into the latch.
// RL7 - First read after pointer load returns an undefined dummy byte.
// RL8 - After read transfer, whole latch reloads from updated pointer address.
// RL9 - Software prepares external writes exactly like internal writes.
// RL10 - Software masks interrupts, raises voltage, clears watchdog, writes, verifies.
// RL11 - One word moves as two byte operations through the latch.
// RL12 - External access only in extended or microprocessor mode.
// RL13 - Byte select picks high or low latch byte.
`timescale 1ns/1ps
module pmta_table_access
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic op_valid,
  output logic op_ready,
  input wire pmta_pkg::pmta_op_type op_code,
  input wire logic op_high_byte,
  input wire logic op_increment,
  input wire logic [7:0] op_data,
  input wire logic external_mode,
  output logic [7:0] read_byte,
  output logic read_byte_valid,
  output logic [15:0] program_word_pointer,
  output logic [15:0] program_word_latch,
  output logic ext_addr_strobe,
  output logic ext_read_enable,
  output logic ext_write_strobe,
  output logic [15:0] ext_ad_out,
  output logic ext_ad_oe,
  input wire logic [15:0] ext_ad_in,
  output logic int_mem_write,
  output logic int_mem_read,
  output logic [15:0] int_mem_addr,
  output logic [15:0] int_mem_wdata,
  input wire logic [15:0] int_mem_rdata,
  input wire logic [2:0] core_flag_pending,
  input wire logic peripheral_pending,
  output logic [2:0] core_flag_clear,
  output logic peripheral_ack
);
  pmta_pkg::pmta_state_type state_q;
  pmta_pkg::pmta_state_type state_d;
  logic [15:0] ptr_q;
  logic [15:0] ptr_d;
  logic [15:0] latch_q;
  logic [15:0] latch_d;
  logic inc_q;
  logic ext_q;
  logic [7:0] rbyte_q;
  logic [7:0] rbyte_d;
  logic rvalid_q;
  logic rvalid_d;
  logic ale_q;
  logic oe_q;
  logic wr_q;
  logic [15:0] ad_q;
  logic ad_oe_q;
  logic ale_d;
  logic oe_d;
  logic wr_d;
  logic [15:0] ad_d;
  logic ad_oe_d;
  wire logic idle;
  wire logic take;
  wire logic write_done;
  wire logic [15:0] fetched;
  wire logic [15:0] ptr_next;
  wire logic [15:0] ptr_take_next;
  wire logic ext_q_next;

  function automatic logic [15:0] bump(input logic [15:0] p, input logic inc);
    bump = inc ? p + pmta_pkg::ptr_step : p;
  endfunction

  function automatic logic [15:0] put_byte(input logic [15:0] w, input logic hi,
    input logic [7:0] b);
    put_byte = hi ? {b, w[7:0]} : {w[15:8], b};
  endfunction

  function automatic logic [7:0] get_byte(input logic [15:0] w, input logic hi);
    get_byte = hi ? w[15:8] : w[7:0];
  endfunction

  assign idle = (state_q == pmta_pkg::pmta_st_idle);
  // Core stalls while a two-cycle access runs
  assign op_ready = idle;
  assign take = idle && op_valid;
  // RL12 external only in extended modes
  assign fetched = ext_q ? ext_ad_in : int_mem_rdata;
  // RL5 pointer step after access
  assign ptr_next = bump(ptr_q, inc_q);
  // Read steps at acceptance so the refetch address is known in cycle one
  assign ptr_take_next = bump(ptr_q, op_increment);
  assign ext_q_next = take ? external_mode : ext_q;
  assign write_done = (state_q == pmta_pkg::pmta_st_wr_second) && ext_q;

  // RL1 fixed two-cycle sequence
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      pmta_pkg::pmta_st_idle:
      begin
        if (take && op_code == pmta_pkg::pmta_op_table_write)
          state_d = pmta_pkg::pmta_st_wr_first;
        else if (take && op_code == pmta_pkg::pmta_op_table_read)
          state_d = pmta_pkg::pmta_st_rd_first;
      end
      // RL3 no abort path exists
      pmta_pkg::pmta_st_wr_first: state_d = pmta_pkg::pmta_st_wr_second;
      pmta_pkg::pmta_st_wr_second: state_d = pmta_pkg::pmta_st_idle;
      pmta_pkg::pmta_st_rd_first: state_d = pmta_pkg::pmta_st_rd_second;
      pmta_pkg::pmta_st_rd_second: state_d = pmta_pkg::pmta_st_idle;
      default: state_d = pmta_pkg::pmta_st_idle;
    endcase
  end

  always_comb
  begin
    ptr_d = ptr_q;
    latch_d = latch_q;
    rbyte_d = rbyte_q;
    rvalid_d = 1'b0;
    if (take)
    begin
      case (op_code)
        // RL13 byte select on latch load
        pmta_pkg::pmta_op_latch_load: latch_d = put_byte(latch_q, op_high_byte, op_data);
        pmta_pkg::pmta_op_table_write: latch_d = put_byte(latch_q, op_high_byte, op_data);
        // RL11 byte transfer out of latch
        pmta_pkg::pmta_op_latch_read:
        begin
          rbyte_d = get_byte(latch_q, op_high_byte);
          rvalid_d = 1'b1;
        end
        // RL7 byte is stale latch content
        pmta_pkg::pmta_op_table_read:
        begin
          rbyte_d = get_byte(latch_q, op_high_byte);
          rvalid_d = 1'b1;
          // RL8 refetch from updated pointer
          ptr_d = ptr_take_next;
        end
        pmta_pkg::pmta_op_ptr_load: ptr_d = put_byte(ptr_q, op_high_byte, op_data);
        default: ptr_d = ptr_q;
      endcase
    end
    // RL6 latch filled from program memory
    if (state_q == pmta_pkg::pmta_st_rd_second)
      latch_d = fetched;
    if (state_q == pmta_pkg::pmta_st_wr_second)
      ptr_d = ptr_next;
  end

  // RL2 bus phases of the access
  always_comb
  begin
    ale_d = 1'b0;
    oe_d = 1'b0;
    wr_d = 1'b0;
    ad_d = 16'h0000;
    ad_oe_d = 1'b0;
    if (state_d == pmta_pkg::pmta_st_wr_first && ext_q_next)
    begin
      ale_d = 1'b1;
      ad_d = ptr_q;
      ad_oe_d = 1'b1;
    end
    else if (state_d == pmta_pkg::pmta_st_wr_second && ext_q)
    begin
      wr_d = 1'b1;
      ad_d = latch_q;
      ad_oe_d = 1'b1;
    end
    // Address in cycle one so data stands while the latch loads
    else if (state_d == pmta_pkg::pmta_st_rd_first && ext_q_next)
    begin
      ale_d = 1'b1;
      ad_d = ptr_take_next;
      ad_oe_d = 1'b1;
    end
    else if (state_d == pmta_pkg::pmta_st_rd_second && ext_q)
      oe_d = 1'b1;
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      state_q <= pmta_pkg::pmta_st_idle;
      ptr_q <= pmta_pkg::ptr_reset;
      latch_q <= pmta_pkg::latch_reset;
      inc_q <= 1'b0;
      ext_q <= 1'b0;
      rbyte_q <= 8'h00;
      rvalid_q <= 1'b0;
      ale_q <= 1'b0;
      oe_q <= 1'b0;
      wr_q <= 1'b0;
      ad_q <= 16'h0000;
      ad_oe_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      ptr_q <= ptr_d;
      latch_q <= latch_d;
      inc_q <= take ? op_increment : inc_q;
      ext_q <= ext_q_next;
      rbyte_q <= rbyte_d;
      rvalid_q <= rvalid_d;
      ale_q <= ale_d;
      oe_q <= oe_d;
      wr_q <= wr_d;
      ad_q <= ad_d;
      ad_oe_q <= ad_oe_d;
    end
  end

  // Internal memory path used outside the extended modes
  assign int_mem_write = (state_q == pmta_pkg::pmta_st_wr_second) && !ext_q;
  assign int_mem_read = (state_q == pmta_pkg::pmta_st_rd_second) && !ext_q;
  assign int_mem_addr = ptr_q;
  assign int_mem_wdata = latch_q;
  assign read_byte = rbyte_q;
  assign read_byte_valid = rvalid_q;
  assign program_word_pointer = ptr_q;
  assign program_word_latch = latch_q;
  assign ext_addr_strobe = ale_q;
  assign ext_read_enable = oe_q;
  assign ext_write_strobe = wr_q;
  assign ext_ad_out = ad_q;
  assign ext_ad_oe = ad_oe_q;

  // RL4 flag clear at write end
  pmta_irq_clear u_irq_clear
  (
    .clk_sys(clk_sys),
    .reset(reset),
    .write_done(write_done),
    .core_flag_pending(core_flag_pending),
    .peripheral_pending(peripheral_pending),
    .core_flag_clear(core_flag_clear),
    .peripheral_ack(peripheral_ack)
  );
endmodule // pmta_table_access

// >>> tb/pmta_ext_mem.sv
// External program memory model on the multiplexed bus
`timescale 1ns/1ps
module pmta_ext_mem
(
  input logic clk_sys,
  input logic ext_addr_strobe,
  input logic ext_read_enable,
  input logic ext_write_strobe,
  input logic [15:0] ext_ad_out,
  output logic [15:0] ext_ad_in
);
  logic [15:0] mem [0:65535];
  logic [15:0] addr_q = 16'h0000;
  initial
    for (int i = 0; i < 65536; i++)
      mem[i] = 16'(i) ^ 16'hA5C3;
  // Idle bus shows inverse so stale data never passes
  assign ext_ad_in = ext_read_enable ? mem[addr_q] : ~mem[addr_q];
  always @(posedge clk_sys)
  begin
    if (ext_addr_strobe)
      addr_q <= ext_ad_out;
    if (ext_write_strobe)
      mem[addr_q] <= ext_ad_out;
  end
endmodule // pmta_ext_mem

// >>> tb/pmta_table_access_asserts.sv
// Port timing checks for the table access block
`timescale 1ns/1ps
module pmta_table_access_asserts
(
  input logic clk_sys,
  input logic reset,
  input logic op_valid,
  input logic op_ready,
  input pmta_pkg::pmta_op_type op_code,
  input logic op_high_byte,
  input logic op_increment,
  input logic external_mode,
  input logic [7:0] read_byte,
  input logic read_byte_valid,
  input logic [15:0] program_word_pointer,
  input logic [15:0] program_word_latch,
  input logic ext_addr_strobe,
  input logic ext_read_enable,
  input logic ext_write_strobe,
  input logic [15:0] ext_ad_out,
  input logic ext_ad_oe,
  input logic [2:0] core_flag_pending,
  input logic [2:0] core_flag_clear,
  input logic peripheral_ack
);
  wire t = op_valid && op_ready;
  wire wx = t && external_mode && op_code == pmta_pkg::pmta_op_table_write;
  wire rx = t && external_mode && op_code == pmta_pkg::pmta_op_table_read;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  AST_WR_TWO: assert property (
    wx |=> ext_addr_strobe && !op_ready ##1 ext_write_strobe && !op_ready ##1 op_ready)
    else $error("write length wrong");
  AST_WR_DATA: assert property (
    ext_write_strobe |-> ext_ad_oe && ext_ad_out == program_word_latch) else $error("write data");
  AST_WR_IRQ: assert property (
    wx && core_flag_pending != 3'h0 |-> ##2 ext_write_strobe) else $error("write aborted");
  AST_CLR: assert property (
    core_flag_clear != 3'h0 || peripheral_ack |-> $onehot({core_flag_clear, peripheral_ack})
    && $past(!op_ready)) else $error("flag clear");
  AST_RD_INC: assert property (
    rx |=> program_word_pointer == $past(program_word_pointer) + {15'h0, $past(op_increment)})
    else $error("pointer step");
  AST_RD_ADDR: assert property (
    rx |=> ext_addr_strobe && ext_ad_out == program_word_pointer ##1 ext_read_enable && !ext_ad_oe)
    else $error("read fetch");
  AST_LOCAL: assert property (
    t && !external_mode |=> !ext_addr_strobe ##1 !ext_write_strobe && !ext_read_enable)
    else $error("bus used");
  AST_LAT_RD: assert property (
    t && op_code == pmta_pkg::pmta_op_latch_read |=> read_byte_valid && read_byte ==
    ($past(op_high_byte) ? $past(program_word_latch[15:8]) : $past(program_word_latch[7:0])))
    else $error("latch byte");
endmodule // pmta_table_access_asserts

// >>> tb/program_memory_table_access_tb_top.sv
// Self-checking bench for the table access block
`timescale 1ns/1ps
module program_memory_table_access_tb_top;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic op_valid = 1'b0;
  logic op_high_byte = 1'b0;
  logic op_increment = 1'b0;
  logic external_mode = 1'b1;
  logic peripheral_pending = 1'b0;
  logic [7:0] op_data = 8'h00;
  logic [2:0] core_flag_pending = 3'h0;
  pmta_pkg::pmta_op_type op_code = pmta_pkg::pmta_op_latch_load;
  logic op_ready, read_byte_valid, ext_addr_strobe, ext_read_enable, ext_write_strobe;
  logic ext_ad_oe, int_mem_write, int_mem_read, peripheral_ack;
  logic [7:0] read_byte;
  logic [2:0] core_flag_clear;
  logic [15:0] program_word_pointer, program_word_latch, ext_ad_out, ext_ad_in;
  logic [15:0] int_mem_addr, int_mem_wdata, ptr = 16'h0000, lat = 16'h0000;
  wire [15:0] int_word = int_mem_addr ^ 16'h3C5A;
  wire [15:0] int_mem_rdata = int_mem_read ? int_word : ~int_word;
  integer seed = 12230;
  integer error_cnt = 0;
  integer check_count = 0;
  integer cyc = 0;
  integer dummy = 1;
  integer i, r, rq, e;
  logic [15:0] m [0:65535];
  integer exp_q [$];
  logic [15:0] wq [$];
  pmta_table_access dut (.*);
  pmta_ext_mem u_mem (.*);
  initial
    forever #5 clk_sys = ~clk_sys;
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t word %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t byte %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    if (error_cnt == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic do_op(input integer c, input logic hi, input logic inc, input logic [7:0] d);
    logic [7:0] b;
    op_valid <= 1'b1;
    op_code <= pmta_pkg::pmta_op_type'(c[2:0]);
    op_high_byte <= hi;
    op_increment <= inc;
    op_data <= d;
    do @(negedge clk_sys); while (op_ready !== 1'b1);
    cmp_word(program_word_pointer, ptr);
    cmp_word(program_word_latch, lat);
    b = hi ? lat[15:8] : lat[7:0];
    case (c)
      0: lat = hi ? {d, lat[7:0]} : {lat[15:8], d};
      1: exp_q.push_back(b);
      2:
      begin
        lat = hi ? {d, lat[7:0]} : {lat[15:8], d};
        if (external_mode)
          m[ptr] = lat;
        else
        begin
          wq.push_back(ptr);
          wq.push_back(lat);
        end
        ptr = ptr + 16'(inc);
      end
      3: begin exp_q.push_back(dummy ? -1 : b); ptr = ptr + 16'(inc); dummy = 0;
        lat = external_mode ? m[ptr] : ptr ^ 16'h3C5A; end
      default: begin ptr = hi ? {d, ptr[7:0]} : {ptr[15:8], d}; dummy = 1; end
    endcase
    @(posedge clk_sys);
  endtask
  always @(negedge clk_sys)
    if (read_byte_valid === 1'b1)
    begin
      e = exp_q.pop_front();
      // Dummy byte after a pointer load is not compared
      if (e >= 0)
        cmp_byte(read_byte, e[7:0]);
    end
  always @(negedge clk_sys)
    if (int_mem_write === 1'b1)
    begin
      cmp_word(int_mem_addr, wq.pop_front());
      cmp_word(int_mem_wdata, wq.pop_front());
    end
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    rq = $random(seed);
    core_flag_pending <= (core_flag_pending & ~core_flag_clear) | (rq[7:4] == 0 ? rq[2:0] : 3'h0);
    peripheral_pending <= (peripheral_pending & ~peripheral_ack) | (rq[11:8] == 0 && rq[3]);
    if (cyc == 5000)
    begin
      error_cnt++;
      wrap_up();
    end
  end
  initial
  begin
    for (i = 0; i < 65536; i++)
      m[i] = 16'(i) ^ 16'hA5C3;
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    for (i = 0; i < 2; i++)
    begin
      // Top address wrap: write at FFFF steps pointer to 0000, then reads after loading 00FF fetch 0100 and 0101 with no readback of FFFF
      do_op(4, 1, 0, 8'hFF);
      do_op(4, 0, 0, 8'hFF);
      do_op(0, 1, 0, 8'h5A);
      do_op(2, 0, 1, 8'h00);
      do_op(4, 0, 0, 8'hFF);
      do_op(3, 0, 1, 8'h00);
      do_op(3, 1, 1, 8'h00);
      external_mode <= 1'b0;
    end
    for (i = 0; i < 300; i++)
    begin
      r = $random(seed);
      if (i % 100 == 50)
        external_mode <= ~external_mode;
      do_op(r[23:16] % 5, r[0], r[1], r[15:8]);
    end
    op_valid <= 1'b0;
    repeat (4) @(negedge clk_sys);
    cmp_word(program_word_pointer, ptr);
    cmp_word(program_word_latch, lat);
    wrap_up();
  end
endmodule // program_memory_table_access_tb_top
bind pmta_table_access pmta_table_access_asserts u_chk (.*);
